// ==== design/gsp_gpio_top.sv ====
`timescale 1ns/100ps
// How it works
// - Reset output low while switched 3.3 V low
// - Manual reset high asserts reset by default
// - Option inverts manual reset sense to low
// - First debug pin gives address bit four
// - Bus power strap holds power paths off in dead-battery boot
// - Pin 4 serves as hot-plug transmit/receive
// - Pin 5 may be hot-plug receive input
// - Pin 0 drives mux select high/low/float
// - Pin 3 drives mux enable
// - Pin 14 drives mux cable polarity
// - Each pin except 9, 10 and 11 configurable as push-pull or input
// - Second debug pin gives address bit five
// - Hardware reset rise gives one reload request pulse
module gsp_gpio_top (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [gsp_pkg::PIN_COUNT-1:0] i_pin_in,
    output logic [gsp_pkg::PIN_COUNT-1:0] o_pin_out,
    output logic [gsp_pkg::PIN_COUNT-1:0] o_pin_oe_n,
    output logic [gsp_pkg::PIN_COUNT-1:0] o_gpio_in,
    input wire logic [gsp_pkg::PIN_COUNT-1:0] i_gpio_oe,
    input wire logic [gsp_pkg::PIN_COUNT-1:0] i_gpio_out,
    input wire logic i_switched_3v3_output,
    input wire logic i_manual_reset_in_active_low,
    input wire logic i_hardware_reset_in,
    input wire logic i_dp_mode_supported,
    input wire logic i_ss_mux_alt_en,
    input wire logic [1:0] i_altmode_select_mode,
    input wire logic i_ss_mux_enable,
    input wire logic i_ss_mux_polarity,
    input wire logic [1:0] i_hpd_txrx_mode,
    input wire logic i_hpd_rx_en,
    input wire logic i_hpd_tx_level,
    input wire logic i_adc_valid,
    input wire logic i_adc_strap_high,
    input wire logic i_dead_battery_boot,
    output logic o_hpd_txrx_rx,
    output logic o_hpd_rx,
    output logic o_sys_reset_active,
    output logic o_reload_request,
    output logic o_straps_valid,
    output logic o_i2c_addr_b4,
    output logic o_i2c_addr_b5,
    output logic [2:0] o_config_strap,
    output logic o_bus_power_strap,
    output logic o_internal_hv_power_path_block,
    output logic o_external_power_path_block
);
    import gsp_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [PIN_COUNT-1:0] pin_meta; // First stage, read only by pin_sync
    logic [PIN_COUNT-1:0] pin_sync; // Pin levels in the clock domain
    logic [1:0] misc_meta; // First stage for 3.3 V and hardware reset
    logic [1:0] misc_sync; // Bit 0 switched 3.3 V, bit 1 hardware reset
    logic hw_reset_d; // Previous hardware reset level

    // Two flip-flops on every pin and on the 3.3 V and hardware reset levels
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            pin_meta <= 18'h00000;
            pin_sync <= 18'h00000;
            misc_meta <= 2'h0;
            misc_sync <= 2'h0;
        end else begin
            pin_meta <= i_pin_in;
            pin_sync <= pin_meta;
            misc_meta <= {i_hardware_reset_in, i_switched_3v3_output};
            misc_sync <= misc_meta;
        end
    end

    // ------------------------------------------------------------
    // Strap sampling
    // ------------------------------------------------------------
    gsp_strap_if strap ();

    // Pin straps and ADC strap latched once per reset
    gsp_strap_latch u_strap_latch (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_pin_sync(pin_sync),
        .i_adc_valid(i_adc_valid),
        .i_adc_strap_high(i_adc_strap_high),
        .i_dead_battery_boot(i_dead_battery_boot),
        .strap(strap.sampler)
    );

    // Strap results straight from the latch flip-flops
    assign o_straps_valid = strap.valid;
    assign o_i2c_addr_b4 = strap.addr_b4;
    assign o_i2c_addr_b5 = strap.addr_b5;
    assign o_config_strap = strap.config_strap;
    assign o_bus_power_strap = strap.bus_power_strap;
    assign o_internal_hv_power_path_block = strap.path_block;
    assign o_external_power_path_block = strap.path_block;

    // ------------------------------------------------------------
    // System reset and hardware reset request
    // ------------------------------------------------------------
    logic manual_reset_in_active; // Manual reset after sense selection
    logic reset_assert; // System reset output should be low

    assign manual_reset_in_active = pin_sync[PIN_MANUAL_RESET_IN] ^ i_manual_reset_in_active_low;
    assign reset_assert = !misc_sync[0] || manual_reset_in_active;

    // Reset indication and reload pulse on hardware reset rise
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_sys_reset_active <= 1'b1;
            hw_reset_d <= 1'b0;
            o_reload_request <= 1'b0;
        end else begin
            o_sys_reset_active <= reset_assert;
            hw_reset_d <= misc_sync[1];
            o_reload_request <= misc_sync[1] && !hw_reset_d;
        end
    end

    // ------------------------------------------------------------
    // Per-pin output selection
    // ------------------------------------------------------------
    logic [PIN_COUNT-1:0] next_out; // Pin level to drive
    logic [PIN_COUNT-1:0] next_oe_n; // Low where the pin is driven

    for (genvar n = 0; n < PIN_COUNT; n++) begin : g_pin
        logic po; // Selected output level
        logic pe; // Selected output enable, active low

        // Function of each pin, firmware setting as fallback
        always_comb begin
            po = i_gpio_out[n];
            pe = !i_gpio_oe[n];
            if (n == PIN_SYS_RESET) begin
                po = !reset_assert;
                pe = 1'b0;
            end else if (n == PIN_BUS_POWER || n == PIN_MANUAL_RESET_IN) begin
                // Input-only pins
                pe = 1'b1;
            end else if (STRAP_PIN_MASK[n] && !strap.valid) begin
                // Straps float until latched
                pe = 1'b1;
            end else if (n == PIN_AMSEL && i_ss_mux_alt_en) begin
                case (i_altmode_select_mode)
                    AMSEL_LOW: begin
                        po = 1'b0;
                        pe = 1'b0;
                    end
                    AMSEL_HIGH: begin
                        po = 1'b1;
                        pe = 1'b0;
                    end
                    default: begin
                        po = 1'b0;
                        pe = 1'b1;
                    end
                endcase
            end else if (n == PIN_MUX_EN && i_ss_mux_alt_en) begin
                po = i_ss_mux_enable;
                pe = 1'b0;
            end else if (n == PIN_MUX_POL && i_ss_mux_alt_en) begin
                po = i_ss_mux_polarity;
                pe = 1'b0;
            end else if (n == PIN_HPD_TXRX && i_dp_mode_supported
                         && i_hpd_txrx_mode != HPD_OFF) begin
                po = i_hpd_tx_level;
                pe = (i_hpd_txrx_mode == HPD_RX);
            end else if (n == PIN_HPD_RX && i_dp_mode_supported && i_hpd_rx_en) begin
                pe = 1'b1;
            end
        end

        assign next_out[n] = po;
        assign next_oe_n[n] = pe;
    end

    // Pin drivers and read-back registers
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_pin_out <= PIN_OUT_RST;
            o_pin_oe_n <= PIN_OE_N_RST;
            o_gpio_in <= 18'h00000;
            o_hpd_txrx_rx <= 1'b0;
            o_hpd_rx <= 1'b0;
        end else begin
            o_pin_out <= next_out;
            o_pin_oe_n <= next_oe_n;
            o_gpio_in <= pin_sync;
            o_hpd_txrx_rx <= pin_sync[PIN_HPD_TXRX] && i_dp_mode_supported
                             && i_hpd_txrx_mode[1];
            o_hpd_rx <= pin_sync[PIN_HPD_RX] && i_dp_mode_supported && i_hpd_rx_en;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    // Hardware reset rise then reload pulse one cycle later
    sequence s_hw_rise;
        misc_sync[1] && !hw_reset_d;
    endsequence
    sequence s_reload_pulse;
        o_reload_request ##1 !o_reload_request;
    endsequence

    a_reset_3v3_low: assert property (!misc_sync[0] |=> !o_pin_out[PIN_SYS_RESET]
        && !o_pin_oe_n[PIN_SYS_RESET])
        else $error("reset pin not driven low with 3.3 V off");
    a_manual_reset_in_high: assert property (!i_manual_reset_in_active_low && pin_sync[PIN_MANUAL_RESET_IN]
        |=> !o_pin_out[PIN_SYS_RESET] && o_sys_reset_active)
        else $error("manual reset high did not assert reset");
    a_manual_reset_in_low: assert property (i_manual_reset_in_active_low && !pin_sync[PIN_MANUAL_RESET_IN]
        |=> !o_pin_out[PIN_SYS_RESET])
        else $error("inverted manual reset did not assert reset");
    a_reset_release: assert property (misc_sync[0] && !manual_reset_in_active
        |=> o_pin_out[PIN_SYS_RESET])
        else $error("reset pin held low without cause");
    a_hpd_tx: assert property (strap.valid && i_dp_mode_supported
        && i_hpd_txrx_mode == HPD_TX |=> !o_pin_oe_n[PIN_HPD_TXRX])
        else $error("hot-plug transmit pin not driven");
    a_hpd_rx_in: assert property (i_dp_mode_supported && i_hpd_rx_en
        |=> o_pin_oe_n[PIN_HPD_RX])
        else $error("hot-plug receive pin driven");
    a_amsel_float: assert property (i_ss_mux_alt_en && i_altmode_select_mode == AMSEL_FLOAT
        |=> o_pin_oe_n[PIN_AMSEL])
        else $error("select pin not floated");
    a_mux_enable: assert property (i_ss_mux_alt_en && strap.valid
        |=> !o_pin_oe_n[PIN_MUX_EN] && o_pin_out[PIN_MUX_EN] == $past(i_ss_mux_enable))
        else $error("mux enable pin wrong");
    a_mux_polarity: assert property (i_ss_mux_alt_en
        |=> !o_pin_oe_n[PIN_MUX_POL] && o_pin_out[PIN_MUX_POL] == $past(i_ss_mux_polarity))
        else $error("mux polarity pin wrong");
    a_gpio_pushpull: assert property (i_gpio_oe[2] |=> !o_pin_oe_n[2]
        && o_pin_out[2] == $past(i_gpio_out[2]))
        else $error("general pin not driven as configured");
    a_reload_req: assert property (s_hw_rise |=> s_reload_pulse)
        else $error("hardware reset did not raise one reload pulse");
    a_reset_float: assert property (disable iff (1'b0) i_sys_rst |=>
        o_pin_oe_n == PIN_OE_N_RST)
        else $error("pins not floated after reset");
endmodule : gsp_gpio_top

// ==== design/gsp_pkg.sv ====
package gsp_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    // System clock period in ns (100 MHz)
    localparam int CLK_PERIOD_NS = 10;
    // Least settle time for strap pins after reset release, in ns
    localparam int STRAP_SETTLE_NS = 80;
    // Settle time in cycles, rounded up, at least one
    localparam int STRAP_SETTLE_CYC_RAW = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_CYC_RAW < 1) ? 1 : STRAP_SETTLE_CYC_RAW;

    // ------------------------------------------------------------
    // Pin numbering
    // ------------------------------------------------------------
    localparam int PIN_COUNT = 18;
    localparam int PIN_AMSEL = 0;
    localparam int PIN_CFG_A = 1;
    localparam int PIN_MUX_EN = 3;
    localparam int PIN_HPD_TXRX = 4;
    localparam int PIN_HPD_RX = 5;
    localparam int PIN_SYS_RESET = 9;
    localparam int PIN_BUS_POWER = 10;
    localparam int PIN_MANUAL_RESET_IN = 11;
    localparam int PIN_CFG_C = 12;
    localparam int PIN_CFG_B = 13;
    localparam int PIN_MUX_POL = 14;
    localparam int PIN_DBG_A = 16;
    localparam int PIN_DBG_B = 17;

    // Pins that carry board straps, kept undriven until latched
    localparam logic [PIN_COUNT-1:0] STRAP_PIN_MASK = 18'h33002;
    // Pin output register values after reset: all low
    localparam logic [PIN_COUNT-1:0] PIN_OUT_RST = 18'h00000;
    // Output enables after reset: only the system reset pin drives
    localparam logic [PIN_COUNT-1:0] PIN_OE_N_RST = 18'h3FDFF;

    // ------------------------------------------------------------
    // Mode encodings
    // ------------------------------------------------------------
    // Alternate-mode select drive
    localparam logic [1:0] AMSEL_FLOAT = 2'h0;
    localparam logic [1:0] AMSEL_LOW = 2'h1;
    localparam logic [1:0] AMSEL_HIGH = 2'h2;
    // Hot-plug-detect use of the combined pin
    localparam logic [1:0] HPD_OFF = 2'h0;
    localparam logic [1:0] HPD_TX = 2'h1;
    localparam logic [1:0] HPD_RX = 2'h2;
    localparam logic [1:0] HPD_TXRX = 2'h3;

    // Strap latch states
    typedef enum logic [1:0] {
        GSP_ST_SETTLE,
        GSP_ST_LATCH,
        GSP_ST_HOLD
    } gsp_strap_state_t;
endpackage : gsp_pkg

// ==== design/gsp_strap_if.sv ====
`timescale 1ns/100ps
// Latched strap values passed from the strap sampler to the port top
interface gsp_strap_if;
    logic valid; // Pin straps latched
    logic addr_b4; // Target address bit 4
    logic addr_b5; // Target address bit 5
    logic [2:0] config_strap; // Straps c, b, a
    logic bus_power_valid; // Bus power strap sampled by ADC
    logic bus_power_strap; // Bus power strap pulled up
    logic path_block; // Keep power paths disabled

    modport sampler (output valid, addr_b4, addr_b5, config_strap,
                     bus_power_valid, bus_power_strap, path_block);
    modport user (input valid, addr_b4, addr_b5, config_strap,
                  bus_power_valid, bus_power_strap, path_block);
endinterface : gsp_strap_if

// ==== design/gsp_strap_latch.sv ====
`timescale 1ns/100ps
module gsp_strap_latch (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [gsp_pkg::PIN_COUNT-1:0] i_pin_sync,
    input wire logic i_adc_valid,
    input wire logic i_adc_strap_high,
    input wire logic i_dead_battery_boot,
    gsp_strap_if.sampler strap
);
    import gsp_pkg::*;

    // ------------------------------------------------------------
    // Settle counter and latch sequence
    // ------------------------------------------------------------
    gsp_strap_state_t state; // Latch sequence state
    logic [7:0] settle_cnt; // Cycles since reset release, stops at STRAP_SETTLE_CYC

    // Wait for synchronised pins to settle, latch once, then hold
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            state <= GSP_ST_SETTLE;
            settle_cnt <= 8'h00;
        end else begin
            case (state)
                GSP_ST_SETTLE: begin
                    settle_cnt <= settle_cnt + 8'h01;
                    if (settle_cnt == 8'(STRAP_SETTLE_CYC - 1)) begin
                        state <= GSP_ST_LATCH;
                    end
                end
                GSP_ST_LATCH: begin
                    state <= GSP_ST_HOLD;
                end
                GSP_ST_HOLD: begin
                    state <= GSP_ST_HOLD;
                end
                default: begin
                    state <= GSP_ST_SETTLE;
                end
            endcase
        end
    end

    // Capture pin straps in the single latch cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            strap.valid <= 1'b0;
            strap.addr_b4 <= 1'b0;
            strap.addr_b5 <= 1'b0;
            strap.config_strap <= 3'h0;
        end else if (state == GSP_ST_LATCH) begin
            strap.valid <= 1'b1;
            strap.addr_b4 <= i_pin_sync[PIN_DBG_A];
            strap.addr_b5 <= i_pin_sync[PIN_DBG_B];
            strap.config_strap <= {i_pin_sync[PIN_CFG_C], i_pin_sync[PIN_CFG_B],
                                   i_pin_sync[PIN_CFG_A]};
        end
    end

    // ------------------------------------------------------------
    // Bus power strap via ADC
    // ------------------------------------------------------------
    // First ADC result after reset is kept, later ones ignored
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            strap.bus_power_valid <= 1'b0;
            strap.bus_power_strap <= 1'b0;
        end else if (i_adc_valid && !strap.bus_power_valid) begin
            strap.bus_power_valid <= 1'b1;
            strap.bus_power_strap <= i_adc_strap_high;
        end
    end

    // Block paths on dead battery while strap is up or still unknown
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            strap.path_block <= 1'b1;
        end else begin
            strap.path_block <= i_dead_battery_boot &&
                                (strap.bus_power_strap || !strap.bus_power_valid);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_addr_bit4: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        $rose(strap.valid) |-> strap.addr_b4 == $past(i_pin_sync[PIN_DBG_A]))
        else $error("address bit 4 not taken from its strap pin");
    a_addr_bit5: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        $rose(strap.valid) |-> strap.addr_b5 == $past(i_pin_sync[PIN_DBG_B]))
        else $error("address bit 5 not taken from its strap pin");
    a_strap_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        strap.valid |=> strap.valid && $stable(strap.addr_b4) && $stable(strap.addr_b5)
                        && $stable(strap.config_strap))
        else $error("latched straps changed before reset");
    a_strap_time: assert property (@(posedge i_sys_clk)
        $fell(i_sys_rst) |-> !strap.valid [*2])
        else $error("straps latched before settle time");
    a_path_block: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_dead_battery_boot && strap.bus_power_valid && strap.bus_power_strap
        |=> strap.path_block)
        else $error("power paths not held off with bus power strap up");
endmodule : gsp_strap_latch

// ==== verification/gsp_board_model.sv ====
`timescale 1ns/100ps
// Board side of the pads: strap resistors and pull resistors
module gsp_board_model (
    input wire logic [gsp_pkg::PIN_COUNT-1:0] i_pin_out,
    input wire logic [gsp_pkg::PIN_COUNT-1:0] i_pin_oe_n,
    input wire logic [gsp_pkg::PIN_COUNT-1:0] i_pull_level,
    output logic [gsp_pkg::PIN_COUNT-1:0] o_pin_level
);
    import gsp_pkg::*;
    // ------------------------------------------------------------
    // Pad resolution
    // ------------------------------------------------------------
    // strap levels come from i_pull_level
    // A driven pad shows the device level, a released pad its resistor level
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            o_pin_level[i] = i_pin_oe_n[i] ? i_pull_level[i] : i_pin_out[i];
        end
    end
endmodule : gsp_board_model

// ==== verification/gsp_gpio_tb_top.sv ====
`timescale 1ns/100ps
// Self-checking bench for the pin, reset and strap block
module gsp_gpio_tb_top;
    import gsp_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic clk = 1'b0, rst = 1'b1; // Clock and synchronous reset
    logic [PIN_COUNT-1:0] pad, pout, poe_n, gin, goe, gout, pull; // Pads and firmware bits
    logic v33 = 1'b1, mr_low = 1'b0, hw = 1'b0, dp = 1'b0, alt = 1'b0; // Control bits
    logic [1:0] amsel = 2'h0, hmode = 2'h0; // Mode fields
    logic en = 1'b0, pol = 1'b0, rxen = 1'b0, txl = 1'b0; // Mux and hot-plug bits
    logic adv = 1'b0, adh = 1'b0, dead = 1'b0; // Bus power strap sampling
    logic hrx, rx5, ract, rld, sv, b4, b5, bps, hvb, exb; // Outputs
    logic [2:0] cfg; // Latched config straps
    int bad_count = 0, total_checks = 0, cycles = 0;
    initial begin
        forever #5 clk = ~clk;
    end
    gsp_gpio_top DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_pin_in(pad), .o_pin_out(pout),
        .o_pin_oe_n(poe_n), .o_gpio_in(gin), .i_gpio_oe(goe), .i_gpio_out(gout),
        .i_switched_3v3_output(v33), .i_manual_reset_in_active_low(mr_low), .i_hardware_reset_in(hw),
        .i_dp_mode_supported(dp), .i_ss_mux_alt_en(alt), .i_altmode_select_mode(amsel),
        .i_ss_mux_enable(en), .i_ss_mux_polarity(pol), .i_hpd_txrx_mode(hmode),
        .i_hpd_rx_en(rxen), .i_hpd_tx_level(txl), .i_adc_valid(adv), .i_adc_strap_high(adh),
        .i_dead_battery_boot(dead), .o_hpd_txrx_rx(hrx), .o_hpd_rx(rx5),
        .o_sys_reset_active(ract), .o_reload_request(rld), .o_straps_valid(sv),
        .o_i2c_addr_b4(b4), .o_i2c_addr_b5(b5), .o_config_strap(cfg),
        .o_bus_power_strap(bps), .o_internal_hv_power_path_block(hvb),
        .o_external_power_path_block(exb));
    gsp_board_model BOARD (.i_pin_out(pout), .i_pin_oe_n(poe_n), .i_pull_level(pull),
        .o_pin_level(pad));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Wait n edges, then step just past the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // Compare and count
    task automatic chk(input string name, input logic [17:0] seen, input logic [17:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Verdict and end of run
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset state, then straps latched from the board and held
    task automatic t_reset_straps;
        cyc(12);
        chk("oe_n in reset", poe_n, PIN_OE_N_RST);
        chk("reset pin in reset", {17'h0, pout[9]}, 18'h00000);
        rst = 1'b0;
        cyc(12);
        chk("straps valid", sv, 18'h00001);
        chk("addr b4", b4, 18'h00001);
        chk("addr b5", b5, 18'h00000);
        chk("config straps", cfg, 18'h00003);
        chk("reset released", {ract, pout[9]}, 18'h00001);
        pull[16] = 1'b0;
        pull[17] = 1'b1;
        cyc(5);
        chk("addr held", {b5, b4}, 18'h00001);
    endtask : t_reset_straps
    // Manual reset in both senses and rail loss
    task automatic t_reset_out;
        pull[11] = 1'b1;
        cyc(4);
        chk("manual_reset_in high", {ract, pout[9]}, 18'h00002);
        mr_low = 1'b1;
        cyc(4);
        chk("inverted idle", ract, 18'h00000);
        pull[11] = 1'b0;
        cyc(4);
        chk("manual_reset_in low", {ract, pout[9]}, 18'h00002);
        mr_low = 1'b0;
        v33 = 1'b0;
        cyc(4);
        chk("rail low", {ract, pout[9], poe_n[9]}, 18'h00004);
        v33 = 1'b1;
        cyc(4);
        chk("rail back", ract, 18'h00000);
    endtask : t_reset_out
    // Mux select in every mode, enable and polarity
    task automatic t_mux;
        alt = 1'b1;
        for (int m = 0; m < 4; m++) begin
            amsel = m[1:0];
            cyc(2);
            chk("select oe_n", poe_n[0], (m == 1 || m == 2) ? 18'h0 : 18'h1);
            if (m == 1 || m == 2) chk("select level", pout[0], (m == 2) ? 18'h1 : 18'h0);
        end
        for (int k = 0; k < 2; k++) begin
            en = k[0];
            pol = ~k[0];
            cyc(2);
            chk("mux enable", {poe_n[3], pout[3]}, {17'h0, k[0]});
            chk("mux polarity", {poe_n[14], pout[14]}, {17'h0, ~k[0]});
        end
        alt = 1'b0;
    endtask : t_mux
    // Push-pull output, input read, analog strap pin never driven
    task automatic t_gpio;
        goe[2] = 1'b1;
        gout[2] = 1'b1;
        goe[10] = 1'b1;
        cyc(2);
        chk("gpio2 drive", {poe_n[2], pout[2], poe_n[10]}, 18'h00003);
        goe[2] = 1'b0;
        pull[2] = 1'b0; // Released pad falls to its resistor, unlike the driven high
        cyc(4);
        chk("gpio2 input", {poe_n[2], gin[2]}, 18'h00002);
    endtask : t_gpio
    // Hot-plug transmit, receive and both
    task automatic t_hpd;
        dp = 1'b1;
        hmode = HPD_TX;
        txl = 1'b1;
        cyc(2);
        chk("hpd tx", {poe_n[4], pout[4]}, 18'h00001);
        hmode = HPD_RX;
        txl = 1'b0; // A wrongly driven pin would pull the read level low
        pull[4] = 1'b1;
        rxen = 1'b1;
        pull[5] = 1'b1;
        cyc(5);
        chk("hpd rx", {poe_n[4], hrx}, 18'h00003);
        chk("pin5 rx", {poe_n[5], rx5}, 18'h00003);
        hmode = HPD_TXRX;
        txl = 1'b0;
        cyc(5);
        chk("hpd txrx", {poe_n[4], pout[4], hrx}, 18'h00000);
        dp = 1'b0;
    endtask : t_hpd
    // Hardware reset held high gives one reload pulse
    task automatic t_hwreset;
        int n = 0;
        hw = 1'b1;
        repeat (8) begin
            cyc(1);
            n += int'(rld);
        end
        hw = 1'b0;
        chk("reload pulses", n[17:0], 18'h00001);
    endtask : t_hwreset
    // Bus power strap sampled once, paths held off in dead battery
    task automatic t_buspower;
        dead = 1'b1;
        adv = 1'b1;
        adh = 1'b1;
        cyc(1);
        adv = 1'b0;
        cyc(2);
        chk("bus strap", {bps, hvb, exb}, 18'h00007);
        adv = 1'b1;
        adh = 1'b0;
        cyc(1);
        adv = 1'b0;
        cyc(2);
        chk("strap held", {bps, hvb, exb}, 18'h00007);
        dead = 1'b0;
        cyc(2);
        chk("paths freed", {hvb, exb}, 18'h00000);
    endtask : t_buspower
    // ------------------------------------------------------------
    // Main sequence and timeout
    // ------------------------------------------------------------
    initial begin
        goe = '0;
        gout = '0;
        pull = 18'h12002; // Straps: pins 1, 13 and 16 high
        t_reset_straps();
        t_reset_out();
        t_mux();
        t_gpio();
        t_hpd();
        t_hwreset();
        t_buspower();
        results();
    end
    // Cut a hang short well past the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            results();
        end
    end
endmodule : gsp_gpio_tb_top
